/* File: wcs_top.v */
// Summary of operation
// - While freeze command is high, samples are not forwarded to the filter.
// - Filter select turns the filter off or fixes one of eight static levels.
// - Command bit 6 captures the current reading as zero point.
// - Command bit 7 captures the current reading as reference point.
// - Command bit 1 stores captured calibration; stored values then take effect.
// - Stored calibration is non-volatile; command bit 2 erases it.
// - Stores are accepted only after the 120th second tick since the previous write.
// - Steady bit 1 sets after value stays in band longer than window.
// - Tracking start latches sample as band centre and zeroes window timer.
// - Leaving the band clears steady, recentres band and restarts timer.
// - Enabled diagnostics raise an incoming interrupt with a captured record.
// - Cause vanishing raises a going interrupt automatically.
// - Events between incoming and going interrupt are discarded.
// - Fault LED is on from incoming until going interrupt.
// - Sources: aux supply, buffer overflow, comm error, parameter error, range, excitation short.
// - Record: four bytes, kind, bit count, channels, summary, 8 error, 4 ticker.
// - Full record readable as 01h; first four bytes as record 00h.
// - First byte: failure bit 0, external 2, channel 3, aux 4, param 7.
// - Module info byte holds analog class and channel-info bit 4.
// - Fourth byte: buffer overflow bit 3, comm error bit 4, rest reserved.
// - Record reports 8 bits per channel, one channel, analog input kind.
// - Channel byte: param bit 0, excitation short 3, underflow 6, overflow 7.
// - 32-bit microsecond ticker from zero at power-up, captured per event.
`include "wcs_defs.vh"

module wcs_top (
  input  wire        i_mclk,
  input  wire        i_rst_n,
  input  wire        i_sample_valid,
  input  wire [23:0] i_sample,
  input  wire [7:0]  i_cmd_byte,
  input  wire [3:0]  i_filter_select,
  input  wire [23:0] i_settle_tolerance,
  input  wire [15:0] i_settle_window_ms,
  input  wire        i_diag_irq_en,
  input  wire        i_aux_missing,
  input  wire        i_buf_overflow,
  input  wire        i_comm_error,
  input  wire        i_param_error,
  input  wire        i_range_under,
  input  wire        i_range_over,
  input  wire        i_exc_short,
  input  wire        i_nv_valid,
  input  wire [23:0] i_nv_zero,
  input  wire [23:0] i_nv_ref,
  input  wire        i_rd_req,
  input  wire [7:0]  i_rd_record_set,
  input  wire [4:0]  i_rd_index,
  output reg         o_filter_select_valid,
  output reg  [23:0] o_filter_select_sample,
  output reg         o_filter_bypass,
  output reg  [2:0]  o_filter_level,
  output reg  [15:0] o_weigh_status_word,
  output reg  [23:0] o_cal_zero,
  output reg  [23:0] o_cal_ref,
  output reg         o_nv_write,
  output reg         o_nv_erase,
  output reg  [23:0] o_nv_zero,
  output reg  [23:0] o_nv_ref,
  output reg         o_diag_irq_in,
  output reg         o_diag_irq_out,
  output reg         o_fault_led,
  output reg         o_rd_valid,
  output reg         o_rd_error,
  output reg  [7:0]  o_rd_data
);

  localparam ST_IDLE   = 1'b0;
  localparam ST_ACTIVE = 1'b1;

  // Pin synchronisers for diagnostic sources
  wire [`WCS_SRC_N-1:0] src_raw = {i_exc_short, i_range_over, i_range_under, i_param_error,
                                   i_comm_error, i_buf_overflow, i_aux_missing};
  reg  [`WCS_SRC_N-1:0] src_s1_q;
  reg  [`WCS_SRC_N-1:0] src_s2_q;
  reg  [`WCS_SRC_N-1:0] src_s3_q;
  reg  [`WCS_SRC_N-1:0] src_q;

  genvar gi;
  generate
    for (gi = 0; gi < `WCS_SRC_N; gi = gi + 1) begin : g_sync
      always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          src_s1_q[gi] <= 1'b0;
          src_s2_q[gi] <= 1'b0;
          src_s3_q[gi] <= 1'b0;
          src_q[gi]    <= 1'b0;
        end else begin
          src_s1_q[gi] <= src_raw[gi];
          src_s2_q[gi] <= src_s1_q[gi];
          src_s3_q[gi] <= src_s2_q[gi];
          if (src_s2_q[gi] == src_s3_q[gi]) begin
            src_q[gi] <= src_s3_q[gi];
          end
        end
      end
    end
  endgenerate

  // Time base: us, ms and s enables
  reg  [`WCS_PRE_W-1:0]    pre_q;
  reg  [`WCS_MS_CNT_W-1:0] us_in_ms_q;
  reg  [`WCS_S_CNT_W-1:0]  ms_in_s_q;
  reg                      us_tick_q;
  reg                      ms_tick_q;
  reg                      s_tick_q;
  reg  [31:0]              ticker_q;

  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_q      <= {`WCS_PRE_W{1'b0}};
      us_in_ms_q <= {`WCS_MS_CNT_W{1'b0}};
      ms_in_s_q  <= {`WCS_S_CNT_W{1'b0}};
      us_tick_q  <= 1'b0;
      ms_tick_q  <= 1'b0;
      s_tick_q   <= 1'b0;
      ticker_q   <= 32'h0000_0000;
    end else begin
      us_tick_q <= 1'b0;
      ms_tick_q <= 1'b0;
      s_tick_q  <= 1'b0;
      if (pre_q == `WCS_CYC_PER_US - 1) begin
        pre_q     <= {`WCS_PRE_W{1'b0}};
        us_tick_q <= 1'b1;
      end else begin
        pre_q <= pre_q + 1'b1;
      end
      if (us_tick_q) begin
        ticker_q <= ticker_q + 32'h0000_0001;
        if (us_in_ms_q == `WCS_US_PER_MS - 1) begin
          us_in_ms_q <= {`WCS_MS_CNT_W{1'b0}};
          ms_tick_q  <= 1'b1;
        end else begin
          us_in_ms_q <= us_in_ms_q + 1'b1;
        end
      end
      if (ms_tick_q) begin
        if (ms_in_s_q == `WCS_MS_PER_S - 1) begin
          ms_in_s_q <= {`WCS_S_CNT_W{1'b0}};
          s_tick_q  <= 1'b1;
        end else begin
          ms_in_s_q <= ms_in_s_q + 1'b1;
        end
      end
    end
  end

  // Command edge detect
  reg  [7:0] cmd_prev_q;
  wire [7:0] cmd_rise = i_cmd_byte & ~cmd_prev_q;
  wire       freeze   = i_cmd_byte[`WCS_CMD_FREEZE];
  wire [3:0] lvl_off  = i_filter_select - `WCS_FILTER_SELECT_LVL_FIRST;

  // Filter feed and level selection
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmd_prev_q      <= 8'h00;
      o_filter_select_valid    <= 1'b0;
      o_filter_select_sample   <= 24'h00_0000;
      o_filter_bypass <= 1'b1;
      o_filter_level  <= 3'h0;
    end else begin
      cmd_prev_q   <= i_cmd_byte;
      o_filter_select_valid <= i_sample_valid & ~freeze;
      if (i_sample_valid && !freeze) begin
        o_filter_select_sample <= i_sample;
      end
      if (i_filter_select >= `WCS_FILTER_SELECT_LVL_FIRST && i_filter_select <= `WCS_FILTER_SELECT_LVL_LAST) begin
        o_filter_bypass <= 1'b0;
        o_filter_level  <= lvl_off[2:0];
      end else begin
        o_filter_bypass <= 1'b1;
        o_filter_level  <= 3'h0;
      end
    end
  end

  // Calibration capture, store, erase and NV hold-off
  reg  [23:0]            zero_cap_q;
  reg  [23:0]            ref_cap_q;
  reg                    cal_valid_q;
  reg                    loaded_q;
  reg                    nv_locked_q;
  reg  [`WCS_HOLD_W-1:0] hold_s_q;

  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      zero_cap_q  <= 24'h00_0000;
      ref_cap_q   <= 24'h00_0000;
      cal_valid_q <= 1'b0;
      loaded_q    <= 1'b0;
      nv_locked_q <= 1'b0;
      hold_s_q    <= {`WCS_HOLD_W{1'b0}};
      o_cal_zero  <= 24'h00_0000;
      o_cal_ref   <= 24'h00_0000;
      o_nv_write  <= 1'b0;
      o_nv_erase  <= 1'b0;
      o_nv_zero   <= 24'h00_0000;
      o_nv_ref    <= 24'h00_0000;
    end else begin
      o_nv_write <= 1'b0;
      o_nv_erase <= 1'b0;
      if (!loaded_q) begin
        loaded_q    <= 1'b1;
        cal_valid_q <= i_nv_valid;
        o_cal_zero  <= i_nv_zero;
        o_cal_ref   <= i_nv_ref;
      end else begin
        if (cmd_rise[`WCS_CMD_ZERO]) begin
          zero_cap_q <= i_sample;
        end
        if (cmd_rise[`WCS_CMD_REF]) begin
          ref_cap_q <= i_sample;
        end
        if (nv_locked_q && s_tick_q) begin
          if (hold_s_q == `WCS_NV_HOLD_S - 1) begin
            nv_locked_q <= 1'b0;
          end else begin
            hold_s_q <= hold_s_q + 1'b1;
          end
        end
        if (cmd_rise[`WCS_CMD_STORE] && !nv_locked_q) begin
          o_nv_write  <= 1'b1;
          o_nv_zero   <= zero_cap_q;
          o_nv_ref    <= ref_cap_q;
          o_cal_zero  <= zero_cap_q;
          o_cal_ref   <= ref_cap_q;
          cal_valid_q <= 1'b1;
          nv_locked_q <= 1'b1;
          hold_s_q    <= {`WCS_HOLD_W{1'b0}};
        end else if (cmd_rise[`WCS_CMD_ERASE]) begin
          o_nv_erase  <= 1'b1;
          cal_valid_q <= 1'b0;
          o_cal_zero  <= 24'h00_0000;
          o_cal_ref   <= 24'h00_0000;
        end
      end
    end
  end

  // Steady-state detection
  reg  [23:0] centre_q;
  reg  [15:0] win_ms_q;
  reg         tracking_q;
  reg         steady_q;
  wire [24:0] diff     = {i_sample[23], i_sample} - {centre_q[23], centre_q};
  wire [24:0] abs_diff = diff[24] ? (~diff + 25'h000_0001) : diff;
  wire        out_band = abs_diff > {1'b0, i_settle_tolerance};

  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      centre_q   <= 24'h00_0000;
      win_ms_q   <= 16'h0000;
      tracking_q <= 1'b0;
      steady_q   <= 1'b0;
    end else begin
      if (i_sample_valid && !tracking_q) begin
        tracking_q <= 1'b1;
        centre_q   <= i_sample;
        win_ms_q   <= 16'h0000;
      end else if (i_sample_valid && out_band) begin
        steady_q <= 1'b0;
        centre_q <= i_sample;
        win_ms_q <= 16'h0000;
      end else if (tracking_q && ms_tick_q) begin
        if (win_ms_q != 16'hffff) begin
          win_ms_q <= win_ms_q + 16'h0001;
        end
        if (win_ms_q >= i_settle_window_ms) begin
          steady_q <= 1'b1;
        end
      end
    end
  end

  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_weigh_status_word <= 16'h0000;
    end else begin
      o_weigh_status_word                     <= 16'h0000;
      o_weigh_status_word[`WCS_ST_CAL_VALID]  <= cal_valid_q;
      o_weigh_status_word[`WCS_ST_STEADY]     <= steady_q;
      o_weigh_status_word[`WCS_ST_NV_LOCK]    <= nv_locked_q;
    end
  end

  // Diagnostics: record snapshot and interrupt sequencing
  wire       cause    = |src_q;
  wire       ch_err   = src_q[`WCS_SRC_PARAM] | src_q[`WCS_SRC_EXC] |
                        src_q[`WCS_SRC_UNDER] | src_q[`WCS_SRC_OVER];
  wire [7:0] diag_a_n = {src_q[`WCS_SRC_PARAM], 2'b00, src_q[`WCS_SRC_AUX], ch_err,
                         src_q[`WCS_SRC_AUX] | src_q[`WCS_SRC_EXC], 1'b0, cause};
  wire [7:0] diag_d_n = {3'b000, src_q[`WCS_SRC_COMM], src_q[`WCS_SRC_BUFOVF], 3'b000};
  wire [7:0] channel_error_summary_n  = {src_q[`WCS_SRC_OVER], src_q[`WCS_SRC_UNDER], 2'b00,
                         src_q[`WCS_SRC_EXC], 2'b00, src_q[`WCS_SRC_PARAM]};

  reg        diag_st_q;
  reg [7:0]  diag_a_q;
  reg [7:0]  diag_d_q;
  reg [7:0]  channel_error_summary_q;
  reg [31:0] stamp_q;

  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      diag_st_q      <= ST_IDLE;
      diag_a_q       <= 8'h00;
      diag_d_q       <= 8'h00;
      channel_error_summary_q        <= 8'h00;
      stamp_q        <= 32'h0000_0000;
      o_diag_irq_in  <= 1'b0;
      o_diag_irq_out <= 1'b0;
      o_fault_led    <= 1'b0;
    end else begin
      o_diag_irq_in  <= 1'b0;
      o_diag_irq_out <= 1'b0;
      case (diag_st_q)
        ST_IDLE: begin
          if (cause && i_diag_irq_en) begin
            diag_st_q     <= ST_ACTIVE;
            o_diag_irq_in <= 1'b1;
            o_fault_led   <= 1'b1;
            diag_a_q      <= diag_a_n;
            diag_d_q      <= diag_d_n;
            channel_error_summary_q       <= channel_error_summary_n;
            stamp_q       <= ticker_q;
          end
        end
        ST_ACTIVE: begin
          // Record stays frozen while the event window is open
          if (!cause) begin
            diag_st_q      <= ST_IDLE;
            o_diag_irq_out <= 1'b1;
            o_fault_led    <= 1'b0;
            diag_a_q       <= 8'h00;
            diag_d_q       <= 8'h00;
            channel_error_summary_q        <= 8'h00;
          end
        end
        default: begin
          diag_st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Record read port
  reg [7:0] rec_byte;
  always @* begin
    case (i_rd_index)
      `WCS_B_DIAG_A: rec_byte = diag_a_q;
      `WCS_B_MODCLS: rec_byte = `WCS_MODCLS_VAL;
      `WCS_B_RSVD:   rec_byte = 8'h00;
      `WCS_B_DIAG_D: rec_byte = diag_d_q;
      `WCS_B_CHKIND: rec_byte = `WCS_CHKIND_VAL;
      `WCS_B_DIAG_BITS_PER_CHANNEL: rec_byte = `WCS_DIAG_BITS_PER_CHANNEL_VAL;
      `WCS_B_CHANNEL_COUNT:  rec_byte = `WCS_CHANNEL_COUNT_VAL;
      `WCS_B_CHSUM:  rec_byte = {7'h00, |channel_error_summary_q};
      `WCS_B_CHERR0: rec_byte = channel_error_summary_q;
      `WCS_B_TS0:    rec_byte = stamp_q[7:0];
      `WCS_B_TS1:    rec_byte = stamp_q[15:8];
      `WCS_B_TS2:    rec_byte = stamp_q[23:16];
      `WCS_B_TS3:    rec_byte = stamp_q[31:24];
      default:       rec_byte = 8'h00;
    endcase
  end

  wire rd_ok = (i_rd_record_set == `WCS_REC_FULL  && i_rd_index < `WCS_REC_FULL_LEN) ||
               (i_rd_record_set == `WCS_REC_SHORT && i_rd_index < `WCS_REC_SHORT_LEN);

  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_valid <= 1'b0;
      o_rd_error <= 1'b0;
      o_rd_data  <= 8'h00;
    end else begin
      o_rd_valid <= i_rd_req;
      o_rd_error <= i_rd_req & ~rd_ok;
      if (i_rd_req) begin
        o_rd_data <= rd_ok ? rec_byte : 8'h00;
      end
    end
  end

endmodule // wcs_top

/* File: wcs_defs.vh */
`ifndef WCS_DEFS_VH
`define WCS_DEFS_VH

// Timing
`define WCS_CLK_HZ          20000000
`define WCS_US_PER_S        1000000
`define WCS_CYC_PER_US      (`WCS_CLK_HZ / `WCS_US_PER_S)
`define WCS_US_PER_MS       1000
`define WCS_MS_PER_S        1000
`define WCS_NV_HOLD_S       120
`define WCS_PRE_W           5
`define WCS_MS_CNT_W        10
`define WCS_S_CNT_W         10
`define WCS_HOLD_W          7

// Command byte bits
`define WCS_CMD_STORE       1
`define WCS_CMD_ERASE       2
`define WCS_CMD_FREEZE      5
`define WCS_CMD_ZERO        6
`define WCS_CMD_REF         7

// Status word bits
`define WCS_ST_CAL_VALID    0
`define WCS_ST_STEADY       1
`define WCS_ST_NV_LOCK      2

// Filter select codes
`define WCS_FILTER_SELECT_LVL_FIRST  4'h2
`define WCS_FILTER_SELECT_LVL_LAST   4'h9

// Diagnostic source indices
`define WCS_SRC_AUX         0
`define WCS_SRC_BUFOVF      1
`define WCS_SRC_COMM        2
`define WCS_SRC_PARAM       3
`define WCS_SRC_UNDER       4
`define WCS_SRC_OVER        5
`define WCS_SRC_EXC         6
`define WCS_SRC_N           7

// Record numbers and lengths
`define WCS_REC_SHORT       8'h00
`define WCS_REC_FULL        8'h01
`define WCS_REC_SHORT_LEN   5'h04
`define WCS_REC_FULL_LEN    5'h14

// Record byte positions
`define WCS_B_DIAG_A        5'h00
`define WCS_B_MODCLS        5'h01
`define WCS_B_RSVD          5'h02
`define WCS_B_DIAG_D        5'h03
`define WCS_B_CHKIND        5'h04
`define WCS_B_DIAG_BITS_PER_CHANNEL        5'h05
`define WCS_B_CHANNEL_COUNT         5'h06
`define WCS_B_CHSUM         5'h07
`define WCS_B_CHERR0        5'h08
`define WCS_B_TS0           5'h10
`define WCS_B_TS1           5'h11
`define WCS_B_TS2           5'h12
`define WCS_B_TS3           5'h13

// Fixed record values
`define WCS_MODCLS_VAL      8'h15
`define WCS_CHKIND_VAL      8'h71
`define WCS_DIAG_BITS_PER_CHANNEL_VAL      8'h08
`define WCS_CHANNEL_COUNT_VAL       8'h01

`endif

/* File: wcs_monitor.sv */
module wcs_monitor (
  input wire        i_mclk,
  input wire        i_rst_n,
  input wire        i_sample_valid,
  input wire [23:0] i_sample,
  input wire [7:0]  i_cmd_byte,
  input wire [3:0]  i_filter_select,
  input wire        i_diag_irq_en,
  input wire        i_rd_req,
  input wire [7:0]  i_rd_record_set,
  input wire [4:0]  i_rd_index,
  input wire        o_filter_select_valid,
  input wire [23:0] o_filter_select_sample,
  input wire        o_filter_bypass,
  input wire [2:0]  o_filter_level,
  input wire [15:0] o_weigh_status_word,
  input wire [23:0] o_cal_zero,
  input wire [23:0] o_nv_zero,
  input wire        o_nv_write,
  input wire        o_nv_erase,
  input wire        o_diag_irq_in,
  input wire        o_diag_irq_out,
  input wire        o_fault_led,
  input wire        o_rd_valid,
  input wire        o_rd_error,
  input wire [7:0]  o_rd_data
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);
  AST_FILTER_SELECT_FWD: assert property (i_sample_valid && !i_cmd_byte[5] |=> o_filter_select_valid && o_filter_select_sample == $past(i_sample))
    else $error("sample not forwarded");
  AST_FILTER_SELECT_FRZ: assert property (i_sample_valid && i_cmd_byte[5] |=> !o_filter_select_valid)
    else $error("sample forwarded during freeze");
  AST_FSEL_LVL: assert property (i_filter_select inside {[4'h2:4'h9]} |=> !o_filter_bypass && {1'b0, o_filter_level} == $past(i_filter_select) - 4'h2)
    else $error("wrong filter level");
  AST_FSEL_OFF: assert property (!(i_filter_select inside {[4'h2:4'h9]}) |=> o_filter_bypass)
    else $error("filter not off");
  AST_STORE_USE: assert property (o_nv_write |-> o_cal_zero == o_nv_zero ##1 o_weigh_status_word[0] && o_weigh_status_word[2])
    else $error("stored calibration not applied");
  AST_STORE_LOCK: assert property (o_weigh_status_word[2] |-> !o_nv_write)
    else $error("store during lockout");
  AST_CMD_HELD: assert property (i_cmd_byte[1] && $past(i_cmd_byte[1]) |=> !o_nv_write)
    else $error("held store bit repeated");
  AST_ERASE: assert property (o_nv_erase |-> ##[0:1] (o_cal_zero == 24'h000000 && !o_weigh_status_word[0]))
    else $error("erase left calibration");
  AST_IRQ_IN: assert property (o_diag_irq_in |-> ##[0:1] o_fault_led)
    else $error("fault led not on");
  AST_IRQ_OUT: assert property (o_diag_irq_out |-> ##[0:1] !o_fault_led)
    else $error("fault led not off");
  AST_IRQ_DISCARD: assert property (o_fault_led && $past(o_fault_led) |-> !o_diag_irq_in)
    else $error("event inside window raised");
  AST_IRQ_DIS: assert property (!i_diag_irq_en && !o_fault_led |=> !o_diag_irq_in)
    else $error("interrupt while disabled");
  AST_RD_ERR: assert property (i_rd_req && i_rd_record_set == 8'h00 && i_rd_index > 5'h03 |=> o_rd_valid && o_rd_error && o_rd_data == 8'h00)
    else $error("short record bound");
  AST_RD_KIND: assert property (i_rd_req && i_rd_record_set == 8'h01 && i_rd_index == 5'h04 |=> o_rd_valid && o_rd_data == 8'h71)
    else $error("channel kind wrong");
endmodule // wcs_monitor
bind wcs_top wcs_monitor i_wcs_monitor (.*);

/* File: wcs_bus_ctrl.sv */
module wcs_bus_ctrl (
  input  wire logic       i_mclk,
  input  wire logic       i_rd_valid,
  input  wire logic       i_rd_error,
  input  wire logic [7:0] i_rd_data,
  output logic            o_rd_req,
  output logic [7:0]      o_rd_record_set,
  output logic [4:0]      o_rd_index
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_rd_req = 1'b0;
    o_rd_record_set = 8'h00;
    o_rd_index = 5'h00;
  end
  // One byte per request; selectors scrambled once the answer is taken
  task automatic read_rec(input logic [7:0] s, input logic [4:0] i, output logic [7:0] d, output logic e);
    @(posedge i_mclk);
    o_rd_req <= 1'b1;
    o_rd_record_set <= s;
    o_rd_index <= i;
    @(posedge i_mclk);
    o_rd_req <= 1'b0;
    @(posedge i_mclk);
    d = i_rd_valid ? i_rd_data : 8'hxx;
    e = i_rd_valid ? i_rd_error : 1'bx;
    o_rd_record_set <= ~s;
    o_rd_index <= ~i;
  endtask
endmodule // wcs_bus_ctrl

/* File: weigh_cal_settle_diag_tb_top.sv */
module weigh_cal_settle_diag_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_mclk, i_rst_n, i_sample_valid, i_diag_irq_en, i_nv_valid, i_rd_req;
  logic i_aux_missing, i_buf_overflow, i_comm_error, i_param_error, i_range_under, i_range_over, i_exc_short;
  logic [23:0] i_sample, i_settle_tolerance, i_nv_zero, i_nv_ref, o_filter_select_sample, o_cal_zero, o_cal_ref;
  logic [23:0] o_nv_zero, o_nv_ref;
  logic [7:0]  i_cmd_byte, i_rd_record_set, o_rd_data;
  logic [3:0]  i_filter_select;
  logic [15:0] i_settle_window_ms, o_weigh_status_word;
  logic [4:0]  i_rd_index;
  logic [2:0]  o_filter_level;
  logic o_filter_select_valid, o_filter_bypass, o_nv_write, o_nv_erase, o_diag_irq_in, o_diag_irq_out, o_fault_led;
  logic o_rd_valid, o_rd_error;
  logic [6:0]  flt;
  logic [7:0]  ea [7] = '{8'h15, 8'h01, 8'h01, 8'h89, 8'h09, 8'h09, 8'h0d};
  logic [7:0]  ed [7] = '{8'h00, 8'h08, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  ec [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h40, 8'h80, 8'h08};
  int n_mismatch, samples_checked, cyc, n_in, n_out, n_wr, n_er, t_in;
  assign {i_exc_short, i_range_over, i_range_under, i_param_error, i_comm_error, i_buf_overflow, i_aux_missing} = flt;
  wcs_top i_wcs_top (.*);
  wcs_bus_ctrl i_wcs_bus_ctrl (.i_mclk(i_mclk), .i_rd_valid(o_rd_valid), .i_rd_error(o_rd_error),
    .i_rd_data(o_rd_data), .o_rd_req(i_rd_req), .o_rd_record_set(i_rd_record_set), .o_rd_index(i_rd_index));
  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (o_diag_irq_in) begin
      n_in <= n_in + 1;
      t_in <= cyc;
    end
    if (o_diag_irq_out) n_out <= n_out + 1;
    if (o_nv_write) n_wr <= n_wr + 1;
    if (o_nv_erase) n_er <= n_er + 1;
    if (cyc == 75000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] s, input logic [4:0] i, input logic [7:0] e, input logic ee);
    logic [7:0] d;
    logic er;
    i_wcs_bus_ctrl.read_rec(s, i, d, er);
    chk(d, e);
    chk(er, ee);
  endtask
  task automatic wait_cnt(ref int c, input int v);
    for (int w = 0; w < 20 && c < v; w++) @(posedge i_mclk);
    #1;
  endtask
  task automatic cmd_pulse(input int b, input logic [23:0] s);
    @(posedge i_mclk);
    i_sample <= s;
    i_cmd_byte[b] <= 1'b1;
    repeat (3) @(posedge i_mclk);
    i_cmd_byte[b] <= 1'b0;
  endtask
  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    {i_rst_n, i_sample_valid, i_nv_valid, flt, i_cmd_byte, i_filter_select, i_sample} = '0;
    {i_nv_zero, i_nv_ref, cyc, n_in, n_out, n_wr, n_er} = '0;
    i_diag_irq_en = 1'b1;
    i_settle_tolerance = 24'h000010;
    i_settle_window_ms = 16'h0001;
    repeat (12) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_mclk);
    #1 chk(o_weigh_status_word, 16'h0000);
    rd(8'h01, 5'h01, 8'h15, 1'b0);
    rd(8'h01, 5'h02, 8'h00, 1'b0);
    rd(8'h01, 5'h05, 8'h08, 1'b0);
    rd(8'h01, 5'h06, 8'h01, 1'b0);
    rd(8'h01, 5'h0c, 8'h00, 1'b0);
    rd(8'h00, 5'h04, 8'h00, 1'b1);
    rd(8'h01, 5'h14, 8'h00, 1'b1);
    rd(8'h02, 5'h00, 8'h00, 1'b1);
    for (int k = 0; k < 16; k++) begin
      @(posedge i_mclk);
      i_filter_select <= k[3:0];
      @(posedge i_mclk);
      #1 chk(o_filter_bypass, !(k >= 2 && k <= 9));
      if (k >= 2 && k <= 9) chk(o_filter_level, k - 2);
    end
    @(posedge i_mclk);
    {i_sample, i_sample_valid, i_cmd_byte} <= {24'h000123, 1'b1, 8'h20};
    @(posedge i_mclk);
    {i_sample, i_sample_valid, i_cmd_byte} <= {24'h000456, 1'b1, 8'h00};
    #1 chk(o_filter_select_valid, 1'b0);
    @(posedge i_mclk);
    i_sample_valid <= 1'b0;
    #1 chk({o_filter_select_valid, o_filter_select_sample}, {1'b1, 24'h000456});
    cmd_pulse(6, 24'h000100);
    // Reference reading kept well below a fifth of full scale
    cmd_pulse(7, 24'h004100);
    @(posedge i_mclk);
    i_cmd_byte[1] <= 1'b1;
    repeat (12) @(posedge i_mclk);
    #1 chk(n_wr, 1);
    chk({o_cal_zero, o_cal_ref}, {24'h000100, 24'h004100});
    chk({o_nv_zero, o_nv_ref}, {24'h000100, 24'h004100});
    chk({o_weigh_status_word[2], o_weigh_status_word[0]}, 2'b11);
    @(posedge i_mclk);
    i_cmd_byte[1] <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_cmd_byte[1] <= 1'b1;
    repeat (6) @(posedge i_mclk);
    #1 chk(n_wr, 1);
    @(posedge i_mclk);
    i_cmd_byte <= 8'h04;
    repeat (4) @(posedge i_mclk);
    #1 chk(n_er, 1);
    chk({o_cal_zero, o_weigh_status_word[0]}, 25'h0);
    @(posedge i_mclk);
    i_cmd_byte <= 8'h00;
    for (int k = 0; k < 7; k++) begin
      @(posedge i_mclk);
      flt <= 7'h01 << k;
      wait_cnt(n_in, k + 1);
      chk({n_in, o_fault_led}, {k + 1, 1'b1});
      @(posedge i_mclk);
      flt <= flt | (k == 0 ? 7'h02 : 7'h01);
      repeat (8) @(posedge i_mclk);
      rd(8'h01, 5'h00, ea[k], 1'b0);
      rd(8'h00, 5'h03, ed[k], 1'b0);
      rd(8'h01, 5'h07, {7'h0, ec[k] != 8'h00}, 1'b0);
      rd(8'h01, 5'h08, ec[k], 1'b0);
      // Stamp counts microseconds (20 clocks) from the first edge after reset release
      for (int j = 0; j < 4; j++) rd(8'h01, 5'(16 + j), 8'(((t_in - 14) / 20) >> (8 * j)), 1'b0);
      chk(n_in, k + 1);
      flt <= 7'h00;
      wait_cnt(n_out, k + 1);
      chk({n_out, o_fault_led}, {k + 1, 1'b0});
    end
    @(posedge i_mclk);
    {i_diag_irq_en, flt} <= {1'b0, 7'h10};
    repeat (10) @(posedge i_mclk);
    #1 chk(n_in, 7);
    @(posedge i_mclk);
    flt <= 7'h00;
    repeat (8) @(posedge i_mclk);
    {i_diag_irq_en, i_sample, i_sample_valid} <= {1'b1, 24'h002000, 1'b1};
    repeat (5) @(posedge i_mclk);
    i_sample <= 24'h002010;
    repeat (18000) @(posedge i_mclk);
    #1 chk(o_weigh_status_word[1], 1'b0);
    repeat (24000) @(posedge i_mclk);
    #1 chk(o_weigh_status_word[1], 1'b1);
    @(posedge i_mclk);
    i_sample <= 24'h002021;
    repeat (3) @(posedge i_mclk);
    #1 chk(o_weigh_status_word[1], 1'b0);
    repeat (18000) @(posedge i_mclk);
    #1 chk(o_weigh_status_word[1], 1'b0);
    // Mid-run reset: stored calibration comes back from the NV inputs
    @(posedge i_mclk);
    {i_rst_n, i_sample_valid, i_nv_valid, i_nv_zero, i_nv_ref} <= {2'b00, 1'b1, 24'h000100, 24'h004100};
    repeat (2) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_mclk);
    #1 chk({o_weigh_status_word[0], o_cal_zero, o_cal_ref}, {1'b1, 24'h000100, 24'h004100});
    stop_test();
  end
endmodule // weigh_cal_settle_diag_tb_top
